// *** common/sar_pkg.sv ***
// sar_pkg: constants, command codes and carrier structs of the wind sensor readout.
// assumes one 20 MHz system clock and a host that drives commands as one-cycle strobes.
package sar_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int unsigned CLK_HZ = 20_000_000;     // system clock rate
   localparam int unsigned TRIG_TIMEOUT_S = 1;      // trigger silence limit, seconds
   localparam int unsigned TRIG_TIMEOUT_CYC = TRIG_TIMEOUT_S * CLK_HZ;
   localparam int unsigned JITTER_PCT = 5;          // allowed interval variation, percent
   localparam int unsigned JITTER_MUL = 100 / JITTER_PCT;
   ////////////////////////////////////////////////////////////////////////////////
   // bus selector and address ranges
   localparam logic BUS_SERIAL = 1'h0;              // serial device bus
   localparam logic BUS_NETWORK = 1'h1;             // peripheral network bus
   localparam logic [6:0] ADDR_MIN = 7'h01;
   localparam logic [6:0] ADDR_MAX_SERIAL = 7'h0E;  // 14
   localparam logic [6:0] ADDR_MAX_NETWORK = 7'h78; // 120
   localparam int unsigned GROUP_MAX = 15;          // devices one group trigger reaches
   ////////////////////////////////////////////////////////////////////////////////
   // operating codes
   localparam logic [4:0] OP_HOST = 5'h00;          // host triggered, unfiltered
   localparam logic [4:0] OP_BW5 = 5'h05;           // self triggered, 5 Hz filter
   localparam logic [4:0] OP_BW10 = 5'h0A;          // self triggered, 10 Hz filter
   localparam logic [4:0] OP_BW25 = 5'h19;          // self triggered, 25 Hz filter
   localparam logic [2:0] SHIFT_BW5 = 3'h4;         // smoothing shift per bandwidth
   localparam logic [2:0] SHIFT_BW10 = 3'h3;
   localparam logic [2:0] SHIFT_BW25 = 3'h2;
   ////////////////////////////////////////////////////////////////////////////////
   // host commands
   localparam logic [1:0] CMD_MEASURE = 2'h0;       // addressed measure and prompt
   localparam logic [1:0] CMD_MONITOR = 2'h1;       // addressed monitor request
   localparam logic [1:0] CMD_GROUP = 2'h2;         // broadcast group trigger
   localparam logic [1:0] CMD_ACQUIRE = 2'h3;       // addressed acquire signals
   ////////////////////////////////////////////////////////////////////////////////
   // record layout and diagnostic word
   localparam int unsigned MEAS_WORDS = 5;          // x, y, z, sonic temp, diag
   localparam int unsigned MON_WORDS = 4;           // enclosure temp, rh, pitch, roll
   localparam logic [31:0] NAN_WORD = 32'h80000000; // not-a-number marker
   localparam logic [31:0] DIAG_RESET = 32'h00000000;
   localparam int unsigned DIAG_AMP_LOW = 0;
   localparam int unsigned DIAG_AMP_HIGH = 1;
   localparam int unsigned DIAG_TRACK = 2;
   localparam int unsigned DIAG_DELTA_C = 3;
   localparam int unsigned DIAG_ACQ = 4;
   localparam int unsigned DIAG_VOLT = 5;
   localparam int unsigned DIAG_TRIG = 6;
   localparam int unsigned DIAG_HUMID = 7;
   localparam int unsigned DIAG_MEM = 8;
   localparam int unsigned DIAG_USED = 9;           // bits above read zero
   localparam logic [15:0] DELTA_C_MM_S = 16'h0938; // 2.360 m/s in mm/s
   localparam logic [7:0] HUMID_LIMIT_PCT = 8'h50;  // 80 percent
   ////////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic bus_sel;       // 0 serial, 1 network
      logic [6:0] addr;    // device bus address
      logic [4:0] code;    // operating code
   } sar_cfg_t;
   typedef struct packed {
      logic valid;         // one-cycle strobe
      logic [1:0] kind;    // command code
      logic [6:0] addr;    // target address
   } sar_cmd_t;
   typedef struct packed {
      logic amp_low;       // ultrasonic amplitude too small
      logic amp_high;      // ultrasonic amplitude too large
      logic track_poor;    // poor signal lock
      logic supply_low;    // supply below 9.0 V
      logic mem_err;       // signature check failed
   } sar_cond_t;
endpackage : sar_pkg

// *** hw/sar_sync.sv ***
// sar_sync: two-flop synchroniser for a group of pin levels.
// assumes levels that stay put for several clocks; no pulse capture.
`timescale 1ns/10ps
module sar_sync #(
   parameter int unsigned W = 5
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_ff; // first stage, read only by the second
   logic [W-1:0] sync_ff; // second stage
   // both stages reset to quiet levels
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end
   assign q_o = sync_ff;
endmodule : sar_sync

// *** hw/sar_filter.sv ***
// sar_filter: first-order smoothing of one signed channel, one step per sample tick.
// assumes the shift only changes while the sensor is reconfigured.
`timescale 1ns/10ps
module sar_filter #(
   parameter int unsigned W = 32
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic [2:0] shift_i,
   input wire logic signed [W-1:0] x_i,
   output logic signed [W-1:0] y_o
);
   logic signed [W-1:0] acc_ff;  // smoothed value
   logic signed [W:0] err;       // one bit wider so the step never wraps
   logic signed [W:0] step;
   logic signed [W:0] nxt_acc;
   assign err = {x_i[W-1], x_i} - {acc_ff[W-1], acc_ff};
   assign step = err >>> shift_i;
   assign nxt_acc = {acc_ff[W-1], acc_ff} + step;
   // shift trades bandwidth for lag; a bigger shift lags more
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_ff <= '0;
      end else if (tick_i) begin
         acc_ff <= nxt_acc[W-1:0];
      end
   end
   assign y_o = acc_ff;
endmodule : sar_filter

// *** hw/sar_top.sv ***
// sar_top: measurement readout and diagnostic word of the three-axis sonic wind sensor.
// assumes host commands and measurement-core values arrive on clk_sys_i; condition
// pins and the sample tick come from the core too, condition pins pass a synchroniser.
`timescale 1ns/10ps
module sar_top
   import sar_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = TRIG_TIMEOUT_CYC, // shorten in simulation
   parameter int unsigned CNT_W = 26,                     // interval counter width
   parameter int unsigned DW = 32                         // value word width
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire sar_cfg_t cfg_i,
   input wire sar_cmd_t cmd_i,
   input wire logic sample_tick_i,
   input wire logic lock_done_i,
   input wire logic [DW-1:0] wind_x_i,
   input wire logic [DW-1:0] wind_y_i,
   input wire logic [DW-1:0] wind_z_i,
   input wire logic [DW-1:0] sonic_temp_i,
   input wire logic [DW-1:0] enc_temp_i,
   input wire logic [DW-1:0] enc_rh_i,
   input wire logic [DW-1:0] pitch_i,
   input wire logic [DW-1:0] roll_i,
   input wire logic [15:0] sos_x_i,
   input wire logic [15:0] sos_y_i,
   input wire logic [15:0] sos_z_i,
   input wire logic [7:0] rh_pct_i,
   input wire sar_cond_t cond_pin_i,
   output logic out_valid_o,
   output logic [DW-1:0] out_data_o,
   output logic out_last_o,
   output logic [31:0] diag_o,
   output logic acquiring_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // decode helpers
   // address range depends on the bus that is selected
   function automatic logic addr_ok(input logic bus, input logic [6:0] a);
      addr_ok = (a >= ADDR_MIN) && (a <= ((bus == BUS_NETWORK) ? ADDR_MAX_NETWORK
                                                                 : ADDR_MAX_SERIAL));
   endfunction : addr_ok
   // a filtered code is only honoured on the network bus
   function automatic logic self_mode(input logic bus, input logic [4:0] c);
      self_mode = (bus == BUS_NETWORK) && ((c == OP_BW5) || (c == OP_BW10) || (c == OP_BW25));
   endfunction : self_mode

   ////////////////////////////////////////////////////////////////////////////////
   // configuration and command decode
   typedef enum logic [1:0] {SAR_IDLE, SAR_SEND} sar_state_t;
   sar_state_t state_ff;             // stream state
   sar_state_t nxt_state;
   sar_cond_t cond_sync;             // synchronised condition pins
   logic addr_hit;                   // command aimed at this device
   logic is_self;                    // self triggered filtered mode
   logic [2:0] flt_shift;            // shift for the selected bandwidth
   logic cmd_meas;
   logic cmd_mon;
   logic cmd_grp;
   logic cmd_acq;
   logic idle;
   logic pend_ff;                    // group snapshot waiting for its request

   sar_sync #(.W(5)) u_cond_sync (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .d_i(cond_pin_i),
      .q_o(cond_sync)
   );

   assign idle = (state_ff == SAR_IDLE);
   assign addr_hit = addr_ok(cfg_i.bus_sel, cfg_i.addr) && (cmd_i.addr == cfg_i.addr);
   // a code other than 0 on the serial bus falls back to host triggering
   assign is_self = self_mode(cfg_i.bus_sel, cfg_i.code);
   assign flt_shift = (cfg_i.code == OP_BW5) ? SHIFT_BW5 :
                      (cfg_i.code == OP_BW10) ? SHIFT_BW10 : SHIFT_BW25;
   // measure and monitor commands arriving mid-stream are dropped; the host waits for out_last_o
   assign cmd_meas = cmd_i.valid && idle && addr_hit && (cmd_i.kind == CMD_MEASURE);
   assign cmd_mon = cmd_i.valid && idle && addr_hit && (cmd_i.kind == CMD_MONITOR);
   assign cmd_acq = cmd_i.valid && addr_hit && (cmd_i.kind == CMD_ACQUIRE);
   // group trigger is broadcast and only exists on the serial bus
   assign cmd_grp = cmd_i.valid && (cmd_i.kind == CMD_GROUP) && (cfg_i.bus_sel == BUS_SERIAL);

   ////////////////////////////////////////////////////////////////////////////////
   // bandwidth filters, one per science channel
   logic [DW-1:0] sci_raw [4];
   logic [DW-1:0] sci_flt [4];
   assign sci_raw[0] = wind_x_i;
   assign sci_raw[1] = wind_y_i;
   assign sci_raw[2] = wind_z_i;
   assign sci_raw[3] = sonic_temp_i;
   for (genvar g = 0; g < 4; g++) begin : g_flt
      sar_filter #(.W(DW)) u_flt (
         .clk_sys_i(clk_sys_i),
         .rst_n_i(rst_n_i),
         .tick_i(sample_tick_i && is_self),
         .shift_i(flt_shift),
         .x_i(sci_raw[g]),
         .y_o(sci_flt[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // acquire state: set by command, ends when the core reports lock
   logic acq_ff;
   logic nxt_acq;
   assign nxt_acq = cmd_acq ? 1'b1 : (lock_done_i ? 1'b0 : acq_ff);
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acq_ff <= 1'b0;
      end else begin
         acq_ff <= nxt_acq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // trigger timing: silence timeout and interval jitter
   logic trig_evt;                 // one measurement trigger
   logic [CNT_W-1:0] intv_ff;      // cycles since last trigger, saturating
   logic [CNT_W-1:0] prev_ff;      // previous interval
   logic prev_vld_ff;
   logic jit_ff;                   // last interval varied too much
   logic [CNT_W-1:0] intv_diff;
   logic [CNT_W+5:0] diff_scaled;
   logic timeout;
   logic jitter_now;
   logic [CNT_W-1:0] nxt_intv;
   // self modes trigger on the internal sampler, host mode on host requests
   assign trig_evt = is_self ? sample_tick_i :
                     (cmd_grp || (cmd_meas && !pend_ff));
   assign timeout = (intv_ff >= CNT_W'(TIMEOUT_CYC));
   assign intv_diff = (intv_ff > prev_ff) ? (intv_ff - prev_ff) : (prev_ff - intv_ff);
   assign diff_scaled = (CNT_W+6)'(intv_diff) * (CNT_W+6)'(JITTER_MUL);
   assign jitter_now = prev_vld_ff && (diff_scaled > (CNT_W+6)'(prev_ff));
   assign nxt_intv = trig_evt ? '0 : (timeout ? intv_ff : intv_ff + 1'b1);
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         intv_ff <= '0;
         prev_ff <= '0;
         prev_vld_ff <= 1'b0;
         jit_ff <= 1'b0;
      end else begin
         intv_ff <= nxt_intv;
         if (trig_evt) begin
            prev_ff <= intv_ff;
            prev_vld_ff <= !timeout; // a timed-out gap is no reference
            jit_ff <= jitter_now;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // live diagnostic word, evaluated from present conditions
   logic [15:0] sos_max;
   logic [15:0] sos_min;
   logic delta_c;
   logic [31:0] diag_now;
   assign sos_max = (sos_x_i > sos_y_i) ? ((sos_x_i > sos_z_i) ? sos_x_i : sos_z_i)
                                        : ((sos_y_i > sos_z_i) ? sos_y_i : sos_z_i);
   assign sos_min = (sos_x_i < sos_y_i) ? ((sos_x_i < sos_z_i) ? sos_x_i : sos_z_i)
                                        : ((sos_y_i < sos_z_i) ? sos_y_i : sos_z_i);
   assign delta_c = (sos_max - sos_min) > DELTA_C_MM_S;
   always_comb begin
      diag_now = DIAG_RESET;
      diag_now[DIAG_AMP_LOW] = cond_sync.amp_low;
      diag_now[DIAG_AMP_HIGH] = cond_sync.amp_high;
      diag_now[DIAG_TRACK] = cond_sync.track_poor;
      diag_now[DIAG_DELTA_C] = delta_c;
      diag_now[DIAG_ACQ] = acq_ff;
      diag_now[DIAG_VOLT] = cond_sync.supply_low;
      diag_now[DIAG_TRIG] = timeout || jit_ff;
      diag_now[DIAG_HUMID] = rh_pct_i > HUMID_LIMIT_PCT;
      diag_now[DIAG_MEM] = cond_sync.mem_err;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // snapshot taken at a host-mode or group trigger; a group trigger holds it until retrieved
   logic [DW-1:0] snap_ff [4];
   logic [31:0] snap_diag_ff;
   logic take_snap;
   logic nxt_pend;
   logic [DW-1:0] sci_src [4];
   assign take_snap = cmd_grp || (cmd_meas && !pend_ff && !is_self);
   assign nxt_pend = cmd_grp ? 1'b1 : (cmd_meas ? 1'b0 : pend_ff);
   for (genvar g = 0; g < 4; g++) begin : g_src
      assign sci_src[g] = acq_ff ? NAN_WORD : (is_self ? sci_flt[g] : sci_raw[g]);
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_ff <= 1'b0;
         snap_diag_ff <= DIAG_RESET;
         for (int i = 0; i < 4; i++) begin
            snap_ff[i] <= '0;
         end
      end else begin
         pend_ff <= nxt_pend;
         if (take_snap) begin
            snap_diag_ff <= diag_now;
            for (int i = 0; i < 4; i++) begin
               snap_ff[i] <= sci_src[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // record assembly and word stream, one word per clock
   logic [DW-1:0] rec_ff [MEAS_WORDS];
   logic [2:0] idx_ff;
   logic [2:0] len_ff;
   logic [DW-1:0] meas_word [MEAS_WORDS];
   logic use_live;
   logic start;
   // a fresh host-mode or self-mode prompt reads live values, a group one the snapshot
   assign use_live = !pend_ff;
   assign start = cmd_meas || cmd_mon;
   for (genvar g = 0; g < 4; g++) begin : g_word
      assign meas_word[g] = use_live ? sci_src[g] : snap_ff[g];
   end
   assign meas_word[4] = use_live ? diag_now : snap_diag_ff;
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         SAR_IDLE: begin
            if (start) begin
               nxt_state = SAR_SEND;
            end
         end
         SAR_SEND: begin
            if (idx_ff == len_ff - 3'h1) begin
               nxt_state = SAR_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= SAR_IDLE;
         idx_ff <= 3'h0;
         len_ff <= 3'h0;
         for (int i = 0; i < MEAS_WORDS; i++) begin
            rec_ff[i] <= '0;
         end
      end else begin
         state_ff <= nxt_state;
         idx_ff <= (state_ff == SAR_SEND) ? idx_ff + 3'h1 : 3'h0;
         if (cmd_meas) begin
            len_ff <= 3'(MEAS_WORDS);
            for (int i = 0; i < MEAS_WORDS; i++) begin
               rec_ff[i] <= meas_word[i];
            end
         end else if (cmd_mon) begin
            len_ff <= 3'(MON_WORDS);
            rec_ff[0] <= enc_temp_i;
            rec_ff[1] <= enc_rh_i;
            rec_ff[2] <= pitch_i;
            rec_ff[3] <= roll_i;
            rec_ff[4] <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registered outputs
   logic out_valid_ff;
   logic out_last_ff;
   logic [DW-1:0] out_data_ff;
   logic [31:0] diag_ff;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_valid_ff <= 1'b0;
         out_last_ff <= 1'b0;
         out_data_ff <= '0;
         diag_ff <= DIAG_RESET;
      end else begin
         out_valid_ff <= (state_ff == SAR_SEND);
         out_last_ff <= (state_ff == SAR_SEND) && (idx_ff == len_ff - 3'h1);
         out_data_ff <= (state_ff == SAR_SEND) ? rec_ff[idx_ff] : '0;
         diag_ff <= diag_now;
      end
   end
   assign out_valid_o = out_valid_ff;
   assign out_last_o = out_last_ff;
   assign out_data_o = out_data_ff;
   assign diag_o = diag_ff;
   assign acquiring_o = acq_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   sequence meas_req_s;
      cmd_meas;
   endsequence
   sequence five_words_s;
      (out_valid_o && !out_last_o) [*4] ##1 (out_valid_o && out_last_o);
   endsequence
   sequence four_words_s;
      (out_valid_o && !out_last_o) [*3] ##1 (out_valid_o && out_last_o);
   endsequence
   meas_len_a: assert property (meas_req_s |-> ##2 five_words_s)
      else $error("measure record not five words");
   mon_len_a: assert property (cmd_mon |-> ##2 four_words_s)
      else $error("monitor record not four words");
   addr_range_a: assert property ((cmd_meas || cmd_mon) |-> (cfg_i.addr >= ADDR_MIN)
      && (cfg_i.bus_sel ? cfg_i.addr <= ADDR_MAX_NETWORK : cfg_i.addr <= ADDR_MAX_SERIAL))
      else $error("answered outside address range");
   serial_nofilt_a: assert property ((cfg_i.bus_sel == BUS_SERIAL) |-> !is_self)
      else $error("filter active on serial bus");
   high_zero_a: assert property (diag_o[31:DIAG_USED] == '0)
      else $error("undefined diagnostic bits set");
   acq_flag_a: assert property ($rose(acq_ff) |=> diag_o[DIAG_ACQ])
      else $error("acquiring flag missing");
   acq_nan_a: assert property (cmd_meas && acq_ff && !pend_ff |-> ##2 out_data_o == NAN_WORD)
      else $error("science value not nan while acquiring");
   timeout_flag_a: assert property (timeout && !trig_evt |=> diag_o[DIAG_TRIG])
      else $error("trigger timeout not flagged");
   humid_flag_a: assert property (diag_o[DIAG_HUMID] == ($past(rh_pct_i) > HUMID_LIMIT_PCT))
      else $error("humidity flag wrong");
   group_net_a: assert property ((cfg_i.bus_sel == BUS_NETWORK) |-> !cmd_grp ##1 !pend_ff)
      else $error("group trigger acted on network bus");
   group_hold_a: assert property (cmd_grp |=> pend_ff)
      else $error("group snapshot not held");
endmodule : sar_top

// *** verif/sar_host.sv ***
// sar_host: host logger model with a fixed bus, address and code; keeps streamed words.
// assumes registered readout outputs on clk_sys_i.
`timescale 1ns/10ps
module sar_host
   import sar_pkg::*;
#(
   parameter logic [6:0] ADDR = 7'h05
) (
   input wire logic clk_sys_i,
   output sar_cfg_t cfg_o,
   output sar_cmd_t cmd_o,
   input wire logic out_valid_i,
   input wire logic [31:0] out_data_i
);
   logic [31:0] rx[$]; // words seen so far
   // constant serial bus, own address in range, code 0 only
   assign cfg_o = '{bus_sel: BUS_SERIAL, addr: ADDR, code: OP_HOST};
   initial cmd_o = '0;
   // one-cycle strobe, launched just after an edge
   task automatic send(input logic [1:0] kind, input logic [6:0] addr);
      @(posedge clk_sys_i) #1;
      cmd_o = '{valid: 1'h1, kind: kind, addr: addr};
      @(posedge clk_sys_i) #1;
      cmd_o = '0;
   endtask : send
   // capture at the edge where the word stands
   always @(posedge clk_sys_i) begin
      if (out_valid_i) rx.push_back(out_data_i);
   end
endmodule : sar_host

// *** verif/sonic_anemometer_readout_tb.sv ***
// sonic_anemometer_readout_tb: diag flag table, records, refusal, acquire, trigger silence.
// assumes the host model above; silence limit shortened to keep the run short.
`timescale 1ns/10ps
module sonic_anemometer_readout_tb;
   import sar_pkg::*;
   localparam int unsigned TMO = 400; // shortened silence limit
   localparam logic [31:0] WX = 32'h11, WY = 32'h22, WZ = 32'h33, TS = 32'h44;
   typedef struct packed {
      sar_cond_t cond;
      logic [7:0] rh;
      logic [15:0] sosz;
      logic [31:0] diag;
   } sar_row_t;
   // condition pins, humidity, z speed of sound, expected word
   sar_row_t rows [10] = '{'{5'h00, 8'h32, 16'h3000, 32'h000}, '{5'h10, 8'h32, 16'h3000, 32'h001},
      '{5'h08, 8'h32, 16'h3000, 32'h002}, '{5'h04, 8'h32, 16'h3000, 32'h004},
      '{5'h02, 8'h32, 16'h3000, 32'h020}, '{5'h01, 8'h32, 16'h3000, 32'h100},
      '{5'h00, 8'h51, 16'h3000, 32'h080}, '{5'h00, 8'h50, 16'h3938, 32'h000},
      '{5'h00, 8'h32, 16'h3939, 32'h008}, '{5'h1F, 8'h51, 16'h3939, 32'h1AF}};
   logic clk_sys_i = 1'h0, rst_n = 1'h0, lock = 1'h0, tick = 1'h0;
   logic [7:0] rh = 8'h32;
   logic [15:0] sosz = 16'h3000, sosx = 16'h3000;
   sar_cond_t cond = '0;
   sar_cfg_t cfg;
   sar_cmd_t cmd;
   logic out_valid_o, out_last_o, acquiring_o;
   logic [31:0] out_data_o, diag_o;
   int num_errors = 0, check_count = 0;
   always #25 clk_sys_i = ~clk_sys_i; // 20 MHz
   sar_host i_sar_host (.clk_sys_i(clk_sys_i), .cfg_o(cfg), .cmd_o(cmd),
      .out_valid_i(out_valid_o), .out_data_i(out_data_o));
   sar_top #(.TIMEOUT_CYC(TMO)) i_sar_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n),
      .cfg_i(cfg), .cmd_i(cmd), .sample_tick_i(tick), .lock_done_i(lock),
      .wind_x_i(WX), .wind_y_i(WY), .wind_z_i(WZ), .sonic_temp_i(TS),
      .enc_temp_i(32'h55), .enc_rh_i(32'h66), .pitch_i(32'h77), .roll_i(32'h88),
      .sos_x_i(sosx), .sos_y_i(16'h3000), .sos_z_i(sosz), .rh_pct_i(rh),
      .cond_pin_i(cond), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
      .out_last_o(out_last_o), .diag_o(diag_o), .acquiring_o(acquiring_o));
   ////////////////////////////////////////////////////////////////////////////////
   // one compare, four-state exact
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // bounded wait for n captured words
   task automatic wait_rx(input int n);
      for (int i = 0; i < 30 && i_sar_host.rx.size() < n; i++) @(posedge clk_sys_i);
      #1;
      chk(i_sar_host.rx.size(), n);
      if (i_sar_host.rx.size() < n) report_and_stop();
   endtask : wait_rx
   // whole record against expected words, then forget it
   task automatic chk_rec(input logic [31:0] e[$]);
      wait_rx(e.size());
      foreach (e[i]) chk(i_sar_host.rx[i], e[i]);
      i_sar_host.rx.delete();
   endtask : chk_rec
   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk_sys_i);
      #1;
      chk(diag_o, DIAG_RESET);
      chk({out_data_o[30:0], out_valid_o}, 32'h0);
      rst_n = 1'h1;
      $display("reset done");
      // flag table: set and clear of each condition
      foreach (rows[i]) begin
         cond = rows[i].cond;
         rh = rows[i].rh;
         sosz = rows[i].sosz;
         repeat (5) @(posedge clk_sys_i);
         #1;
         chk(diag_o, rows[i].diag);
      end
      cond = '0;
      rh = 8'h32;
      sosz = 16'h3000;
      // x axis slow, spread far above the delta-c limit
      sosx = 16'h2000;
      repeat (5) @(posedge clk_sys_i);
      #1;
      chk(diag_o, 32'h8);
      sosx = 16'h3000;
      $display("flag table done");
      repeat (4) @(posedge clk_sys_i);
      i_sar_host.send(CMD_MEASURE, 7'h05);
      chk_rec({WX, WY, WZ, TS, 32'h0});
      i_sar_host.send(CMD_MONITOR, 7'h05);
      chk_rec({32'h55, 32'h66, 32'h77, 32'h88});
      i_sar_host.send(CMD_MEASURE, 7'h06);
      repeat (10) @(posedge clk_sys_i);
      chk(i_sar_host.rx.size(), 0);
      $display("records done");
      i_sar_host.send(CMD_ACQUIRE, 7'h05);
      i_sar_host.send(CMD_MEASURE, 7'h05);
      wait_rx(5);
      for (int i = 0; i < 4; i++) chk(i_sar_host.rx[i], NAN_WORD);
      chk(i_sar_host.rx[4] & 32'h10, 32'h10);
      chk(acquiring_o, 1'h1);
      i_sar_host.rx.delete();
      lock = 1'h1;
      @(posedge clk_sys_i) #1;
      lock = 1'h0;
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk(diag_o & 32'h10, 32'h0);
      $display("acquire done");
      // group snapshot must not see humidity that rises after the trigger
      i_sar_host.send(CMD_GROUP, 7'h00);
      rh = 8'h51;
      repeat (4) @(posedge clk_sys_i);
      #1;
      chk(diag_o & 32'h80, 32'h80);
      i_sar_host.send(CMD_MEASURE, 7'h05);
      wait_rx(5);
      chk(i_sar_host.rx[0], WX);
      chk(i_sar_host.rx[1], WY);
      chk(i_sar_host.rx[2], WZ);
      chk(i_sar_host.rx[3], TS);
      chk(i_sar_host.rx[4] & 32'h80, 32'h0);
      i_sar_host.rx.delete();
      rh = 8'h32;
      $display("group done");
      // mid-run reset clears jitter history, then silence must raise bit 6
      rst_n = 1'h0;
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk({diag_o[30:0], out_valid_o}, 32'h0);
      rst_n = 1'h1;
      // sampler ticks mean nothing on the serial bus
      tick = 1'h1;
      repeat (TMO - 10) @(posedge clk_sys_i);
      #1;
      chk(diag_o, 32'h0);
      repeat (30) @(posedge clk_sys_i);
      #1;
      chk(diag_o, 32'h40);
      $display("reset and silence done");
      report_and_stop();
   end
endmodule : sonic_anemometer_readout_tb
